//--- rtl/vtc_pkg.sv
// Package of constants and types for the vector termination control block
package vtc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int LEN_W = 16;
  localparam int OP_W = 64;

  // ----------------------------------------------------------------
  // Instruction class boundaries
  // ----------------------------------------------------------------
  localparam logic [7:0] VEC_LO = 8'h80;
  localparam logic [7:0] VEC_HI = 8'h9c;
  localparam logic [7:0] ZERO2_LO = 8'h80;
  localparam logic [7:0] ZERO2_HI = 8'h87;
  localparam logic [7:0] ONE_A = 8'h88;
  localparam logic [7:0] ONE_B = 8'h89;
  localparam logic [7:0] ONE_C = 8'h8b;
  localparam logic [7:0] ONE_D = 8'h8c;
  localparam logic [7:0] ONE_E = 8'h8f;
  localparam logic [7:0] SGL1_LO = 8'h90;
  localparam logic [7:0] SGL1_HI = 8'h93;
  localparam logic [7:0] DUO_A = 8'h94;
  localparam logic [7:0] DUO_B = 8'h95;
  localparam logic [7:0] SGL2_LO = 8'h96;
  localparam logic [7:0] SGL2_HI = 8'h9a;
  localparam logic [7:0] DUO_C = 8'h9b;
  localparam logic [7:0] SGL3 = 8'h9c;

  // ----------------------------------------------------------------
  // Extension values
  // ----------------------------------------------------------------
  localparam logic [OP_W-1:0] MACH_ZERO = 64'h0000_0000_0000_0000;
  localparam logic [OP_W-1:0] NORM_ONE = 64'h0031_8000_0000_0000;
  localparam logic [OP_W-1:0] ALL_ZERO = 64'h0000_0000_0000_0000;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    VTC_FILL_NONE = 2'b00,
    VTC_FILL_ZERO = 2'b01,
    VTC_FILL_ONE = 2'b10
  } vtc_fill_t;

  typedef enum logic [1:0] {
    VTC_IDLE = 2'b00,
    VTC_RUN = 2'b01,
    VTC_DONE = 2'b10
  } vtc_state_t;

endpackage

//--- rtl/vtc_decode.sv
// Opcode classifier for vector and sparse-vector instructions
`timescale 1ns/1ps

module vtc_decode (
  input wire logic [7:0] opcode,
  output vtc_pkg::vtc_fill_t fill_kind,
  output logic use_b,
  output logic is_vector,
  output logic is_sparse
);

  // ----------------------------------------------------------------
  // Range test
  // ----------------------------------------------------------------
  function automatic logic in_rng(input logic [7:0] v, input logic [7:0] lo,
                                  input logic [7:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  logic one_grp;
  logic zero_two;
  logic zero_one;

  always_comb begin
    one_grp = (opcode == vtc_pkg::ONE_A) || (opcode == vtc_pkg::ONE_B) ||
              (opcode == vtc_pkg::ONE_C) || (opcode == vtc_pkg::ONE_D) ||
              (opcode == vtc_pkg::ONE_E);
    zero_two = in_rng(opcode, vtc_pkg::ZERO2_LO, vtc_pkg::ZERO2_HI) ||
               (opcode == vtc_pkg::DUO_A) || (opcode == vtc_pkg::DUO_B) ||
               (opcode == vtc_pkg::DUO_C);
    zero_one = in_rng(opcode, vtc_pkg::SGL1_LO, vtc_pkg::SGL1_HI) ||
               in_rng(opcode, vtc_pkg::SGL2_LO, vtc_pkg::SGL2_HI) ||
               (opcode == vtc_pkg::SGL3);
    is_vector = one_grp || zero_two || zero_one;
    is_sparse = (opcode[7:4] == 4'ha);
    use_b = one_grp || zero_two || is_sparse;
    if (one_grp) begin
      fill_kind = vtc_pkg::VTC_FILL_ONE;
    end else if (zero_two || zero_one) begin
      fill_kind = vtc_pkg::VTC_FILL_ZERO;
    end else begin
      fill_kind = vtc_pkg::VTC_FILL_NONE;
    end
  end

endmodule

//--- rtl/vtc_ctrl.sv
// Termination and extension control for vector and sparse-vector instructions
// Operation
// - If the governing field is empty before the first fetch the instruction is a no-op with no fetch and no flag change.
// - A sparse-vector instruction ends exactly when its result order vector runs out, whatever the source lengths.
// - A zero result order vector designator or zero result order vector length makes a sparse-vector instruction a flagless no-op.
// - Short or empty source order vectors in a sparse-vector instruction read as zero bits where needed.
// - Codes 80 to 87, 94, 95 and 9B extend exhausted A or B fields with machine zero.
// - Codes 88, 89, 8B, 8C and 8F extend exhausted A or B fields with normalized one.
// - Codes 90 to 93, 96 to 9A and 9C use only A, extended with machine zero.
// - Every vector code ends when the C field runs out and is a no-op when C starts empty.
// - Extension values are machine zero or normalized one in the instruction operand format.
`timescale 1ns/1ps

module vtc_ctrl (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [vtc_pkg::LEN_W-1:0] len_a,
  input wire logic [vtc_pkg::LEN_W-1:0] len_b,
  input wire logic [vtc_pkg::LEN_W-1:0] len_c,
  input wire logic c_desig_nz,
  input wire logic z_desig_nz,
  input wire logic step,
  input wire logic [vtc_pkg::OP_W-1:0] fetch_a,
  input wire logic [vtc_pkg::OP_W-1:0] fetch_b,
  input wire logic flags_in_valid,
  output logic busy,
  output logic done,
  output logic noop,
  output logic undefined_op,
  output logic fetch_a_req,
  output logic fetch_b_req,
  output logic [vtc_pkg::OP_W-1:0] opnd_a,
  output logic [vtc_pkg::OP_W-1:0] opnd_b,
  output logic opnd_valid,
  output logic flag_wr_en
);

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  vtc_pkg::vtc_fill_t fill_kind;
  logic use_b;
  logic is_vector;
  logic is_sparse;

  vtc_decode vtc_decode_i (
    .opcode(opcode),
    .fill_kind(fill_kind),
    .use_b(use_b),
    .is_vector(is_vector),
    .is_sparse(is_sparse)
  );

  // ----------------------------------------------------------------
  // Instruction state
  // ----------------------------------------------------------------
  vtc_pkg::vtc_state_t state_r;
  vtc_pkg::vtc_fill_t fill_r;
  logic use_b_r;
  logic sparse_r;
  logic [vtc_pkg::LEN_W-1:0] rem_c_r;
  logic [vtc_pkg::LEN_W-1:0] rem_a_r;
  logic [vtc_pkg::LEN_W-1:0] rem_b_r;
  logic start_noop;
  logic last_step;
  logic [vtc_pkg::OP_W-1:0] fill_val;
  logic take_start;
  logic advance;
  logic a_left;
  logic b_left;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Source field still holds elements to fetch
  function automatic logic has_left(input logic [vtc_pkg::LEN_W-1:0] n);
    has_left = (n != '0);
  endfunction

  // Remaining count after one element
  function automatic logic [vtc_pkg::LEN_W-1:0] count_down(
    input logic [vtc_pkg::LEN_W-1:0] n
  );
    count_down = n - 16'h0001;
  endfunction

  // ----------------------------------------------------------------
  // Step qualifiers
  // ----------------------------------------------------------------
  assign take_start = start && (state_r == vtc_pkg::VTC_IDLE);
  assign advance = (state_r == vtc_pkg::VTC_RUN) && step;
  assign a_left = has_left(rem_a_r);
  assign b_left = use_b_r && has_left(rem_b_r);

  always_comb begin
    start_noop = 1'b0;
    if (is_sparse) begin
      start_noop = !z_desig_nz || (len_c == '0);
    end else if (is_vector) begin
      start_noop = (len_c == '0);
    end else begin
      start_noop = 1'b1;
    end
  end

  always_comb begin
    case (fill_r)
      vtc_pkg::VTC_FILL_ONE: fill_val = vtc_pkg::NORM_ONE;
      vtc_pkg::VTC_FILL_ZERO: fill_val = vtc_pkg::MACH_ZERO;
      default: fill_val = vtc_pkg::ALL_ZERO;
    endcase
    if (sparse_r) begin
      fill_val = vtc_pkg::ALL_ZERO;
    end
  end

  assign last_step = step && (rem_c_r == 16'h0001);

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r <= vtc_pkg::VTC_IDLE;
    end else begin
      case (state_r)
        vtc_pkg::VTC_IDLE: begin
          if (start) begin
            state_r <= start_noop ? vtc_pkg::VTC_DONE : vtc_pkg::VTC_RUN;
          end
        end
        vtc_pkg::VTC_RUN: begin
          if (last_step) begin
            state_r <= vtc_pkg::VTC_DONE;
          end
        end
        vtc_pkg::VTC_DONE: state_r <= vtc_pkg::VTC_IDLE;
        default: state_r <= vtc_pkg::VTC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      fill_r <= vtc_pkg::VTC_FILL_NONE;
      use_b_r <= 1'b0;
      sparse_r <= 1'b0;
    end else if (take_start) begin
      fill_r <= fill_kind;
      use_b_r <= use_b;
      sparse_r <= is_sparse;
    end
  end

  // ----------------------------------------------------------------
  // Length counters
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rem_c_r <= '0;
      rem_a_r <= '0;
      rem_b_r <= '0;
    end else if (take_start) begin
      rem_c_r <= len_c;
      rem_a_r <= len_a;
      rem_b_r <= use_b ? len_b : '0;
    end else if (advance) begin
      rem_c_r <= count_down(rem_c_r);
      if (has_left(rem_a_r)) begin
        rem_a_r <= count_down(rem_a_r);
      end
      if (has_left(rem_b_r)) begin
        rem_b_r <= count_down(rem_b_r);
      end
    end
  end

  // ----------------------------------------------------------------
  // Operand path and outputs
  // ----------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      opnd_a <= '0;
      opnd_b <= '0;
      opnd_valid <= 1'b0;
      fetch_a_req <= 1'b0;
      fetch_b_req <= 1'b0;
    end else begin
      opnd_valid <= advance;
      fetch_a_req <= advance && a_left;
      fetch_b_req <= advance && b_left;
      if (advance) begin
        opnd_a <= a_left ? fetch_a : fill_val;
        if (!use_b_r) begin
          opnd_b <= vtc_pkg::ALL_ZERO;
        end else begin
          opnd_b <= b_left ? fetch_b : fill_val;
        end
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      busy <= 1'b0;
      done <= 1'b0;
      noop <= 1'b0;
      undefined_op <= 1'b0;
      flag_wr_en <= 1'b0;
    end else begin
      busy <= (state_r == vtc_pkg::VTC_RUN) && !last_step;
      done <= (state_r == vtc_pkg::VTC_RUN && last_step) ||
              (take_start && start_noop);
      if (take_start) begin
        noop <= start_noop;
        undefined_op <= is_sparse && z_desig_nz && (len_c != '0) && !c_desig_nz;
      end
      flag_wr_en <= (state_r == vtc_pkg::VTC_RUN) && flags_in_valid;
    end
  end

endmodule

//--- testbench/vtc_ctrl_monitor.sv
// Checker of termination and extension behaviour at the block ports
`timescale 1ns/1ps
module vtc_ctrl_monitor (
  input wire logic mclk,
  input wire logic reset,
  input wire logic start,
  input wire logic [7:0] opcode,
  input wire logic [15:0] len_c,
  input wire logic c_desig_nz,
  input wire logic z_desig_nz,
  input wire logic step,
  input wire logic busy,
  input wire logic done,
  input wire logic noop,
  input wire logic undefined_op,
  input wire logic fetch_a_req,
  input wire logic fetch_b_req,
  input wire logic [63:0] opnd_a,
  input wire logic [63:0] opnd_b,
  input wire logic opnd_valid,
  input wire logic flag_wr_en
);
  logic run_r;
  logic [7:0] op_r;
  logic [15:0] len_r;
  logic [15:0] cnt_r;
  wire take = start && !busy && !done && !run_r;
  wire sp_in = opcode[7:4] == 4'ha;
  wire vec_in = opcode inside {[8'h80:8'h89], 8'h8b, 8'h8c, [8'h8f:8'h9c]};
  wire is_one = op_r inside {8'h88, 8'h89, 8'h8b, 8'h8c, 8'h8f};
  wire is_sgl = op_r inside {[8'h90:8'h93], [8'h96:8'h9a], 8'h9c};
  wire is_zero = op_r inside {[8'h80:8'h9c]} && !is_one && !is_sgl;
  always_ff @(posedge mclk) begin
    if (reset) begin
      run_r <= 1'b0;
    end else if (take) begin
      run_r <= 1'b1;
    end else if (done) begin
      run_r <= 1'b0;
    end
  end
  always_ff @(posedge mclk) begin
    if (take) begin
      op_r <= opcode;
      len_r <= len_c;
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_r + 16'(opnd_valid);
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_end_noop;
    done && noop;
  endsequence
  sequence s_quiet;
    !fetch_a_req && !fetch_b_req && !opnd_valid && !flag_wr_en;
  endsequence
  chk_c_empty_noop: assert property (take && vec_in && len_c == 0 |=> s_end_noop)
    else $error("empty result field did not end as no-op");
  chk_noop_quiet: assert property (noop |-> s_quiet)
    else $error("activity seen during a no-op");
  chk_z_empty_noop: assert property (take && sp_in && (!z_desig_nz || len_c == 0) |=> s_end_noop)
    else $error("empty order vector did not end as no-op");
  chk_undef_flag: assert property (take && sp_in && z_desig_nz && len_c != 0 && !c_desig_nz
    |-> ##[1:2] undefined_op)
    else $error("undefined case not flagged");
  chk_step_answer: assert property (step && busy |=> opnd_valid)
    else $error("step gave no operand");
  chk_end_count: assert property (done && !noop |-> cnt_r + 16'(opnd_valid) == len_r)
    else $error("end not at result length");
  chk_one_fill: assert property (opnd_valid && is_one && !fetch_a_req |-> opnd_a == vtc_pkg::NORM_ONE)
    else $error("one fill value wrong");
  chk_zero_fill: assert property (opnd_valid && is_zero && !fetch_b_req |-> opnd_b == vtc_pkg::MACH_ZERO)
    else $error("zero fill value wrong");
  chk_single_b: assert property (opnd_valid && is_sgl |-> !fetch_b_req && opnd_b == 64'h0)
    else $error("second source used by single source code");
  chk_sparse_pad: assert property (opnd_valid && op_r[7:4] == 4'ha && !fetch_a_req |-> opnd_a == vtc_pkg::ALL_ZERO)
    else $error("sparse padding wrong");
endmodule

//--- testbench/vtc_storage_model.sv
// Central storage model supplying one source word per element
`timescale 1ns/1ps
module vtc_storage_model (
  input wire logic mclk,
  input wire logic start,
  input wire logic step,
  output logic [63:0] fetch_a,
  output logic [63:0] fetch_b
);
  logic [15:0] idx_r;
  always_ff @(posedge mclk) begin
    if (start) begin
      idx_r <= 16'h0000;
    end else if (step) begin
      idx_r <= idx_r + 16'h0001;
    end
  end
  // Words valid only in a step cycle, scrambled otherwise
  assign fetch_a = step ? {48'ha000_0000_0000, idx_r} : ~{48'ha000_0000_0000, idx_r};
  assign fetch_b = step ? {48'hb000_0000_0000, idx_r} : ~{48'hb000_0000_0000, idx_r};
endmodule

//--- testbench/vtc_ctrl_tb.sv
// Testbench for the vector termination control block
`timescale 1ns/1ps
module vtc_ctrl_tb;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic start = 1'b0;
  logic step = 1'b0;
  logic flags_in_valid = 1'b1;
  logic c_desig_nz = 1'b1;
  logic z_desig_nz = 1'b1;
  logic [7:0] opcode = 8'h00;
  logic [15:0] len_a = 16'h0000;
  logic [15:0] len_b = 16'h0000;
  logic [15:0] len_c = 16'h0000;
  logic [63:0] fetch_a, fetch_b, opnd_a, opnd_b;
  logic busy, done, noop, undefined_op, fetch_a_req, fetch_b_req, opnd_valid, flag_wr_en;
  int miscompares = 0;
  int comparisons = 0;
  always #2 mclk = ~mclk;
  vtc_ctrl vtc_ctrl_i (.*);
  vtc_storage_model vtc_storage_model_i (.*);
  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One instruction of n elements, checking every operand
  task automatic run(input logic [7:0] op, input int la, lb, lc, n,
                     input logic [63:0] fa, fb, input logic ub);
    @(negedge mclk);
    opcode = op;
    len_a = 16'(la);
    len_b = 16'(lb);
    len_c = 16'(lc);
    start = 1'b1;
    for (int k = 0; k <= n; k++) begin
      @(negedge mclk);
      start = 1'b0;
      step = (k < n);
      if (k > 0) begin
        chk("opnd_valid", 64'h1, 64'(opnd_valid));
        chk("busy", 64'(k < n), 64'(busy));
        chk("flag_wr_en", 64'(flags_in_valid), 64'(flag_wr_en));
        chk("fetch_b_req", 64'(ub && (k - 1 < lb)), 64'(fetch_b_req));
        chk("fetch_a_req", 64'(k - 1 < la), 64'(fetch_a_req));
        chk("opnd_a", (k - 1 < la) ? {48'ha000_0000_0000, 16'(k - 1)} : fa, opnd_a);
        chk("opnd_b", !ub ? 64'h0 : (k - 1 < lb) ? {48'hb000_0000_0000, 16'(k - 1)} : fb,
            opnd_b);
      end
    end
    chk("done", 64'h1, 64'(done));
    chk("noop", 64'(n == 0), 64'(noop));
    if (n == 0) begin
      chk("flag_wr_en", 64'h0, 64'(flag_wr_en));
    end
    repeat (2) @(negedge mclk);
  endtask
  task automatic s_noop;
    run(8'h80, 3, 3, 0, 0, 64'h0, 64'h0, 1'b1);
    run(8'h8a, 1, 1, 2, 0, 64'h0, 64'h0, 1'b1);
  endtask
  task automatic s_all_codes;
    logic one;
    logic sgl;
    for (int c = 'h80; c <= 'h9c; c++) begin
      if (!(c inside {'h8a, 'h8d, 'h8e})) begin
        one = c inside {'h88, 'h89, 'h8b, 'h8c, 'h8f};
        sgl = c inside {['h90:'h93], ['h96:'h9a], 'h9c};
        run(8'(c), c % 2, 2, 3, 3, one ? vtc_pkg::NORM_ONE : vtc_pkg::MACH_ZERO,
            one ? vtc_pkg::NORM_ONE : vtc_pkg::MACH_ZERO, !sgl);
      end
    end
  endtask
  task automatic s_sparse;
    run(8'ha0, 0, 5, 4, 4, vtc_pkg::ALL_ZERO, vtc_pkg::ALL_ZERO, 1'b1);
    chk("undefined_op", 64'h0, 64'(undefined_op));
    z_desig_nz = 1'b0;
    run(8'ha1, 2, 2, 3, 0, 64'h0, 64'h0, 1'b1);
    z_desig_nz = 1'b1;
    run(8'ha2, 2, 2, 0, 0, 64'h0, 64'h0, 1'b1);
  endtask
  task automatic s_undef;
    c_desig_nz = 1'b0;
    flags_in_valid = 1'b0;
    run(8'ha4, 1, 1, 2, 2, vtc_pkg::ALL_ZERO, vtc_pkg::ALL_ZERO, 1'b1);
    chk("undefined_op", 64'h1, 64'(undefined_op));
    c_desig_nz = 1'b1;
    flags_in_valid = 1'b1;
  endtask
  task automatic tally_and_finish;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(negedge mclk);
    reset = 1'b0;
    chk("busy", 64'h0, 64'(busy));
    s_noop;
    s_all_codes;
    s_sparse;
    s_undef;
    tally_and_finish;
  end
endmodule
bind vtc_ctrl vtc_ctrl_monitor vtc_ctrl_monitor_i (.*);
